// [sdf_decim_filter.sv]
// Summary of operation
// - sinc5 always decimates to 31.25 kSPS
// - sinc5+sinc1 settles in one cycle at <=2.6k
// - sinc3 settling is three output periods
// - map bit: low 15 bits give sinc3 decimation
// - direct rate is modulator rate over 32*value
// - settled-only mode emits settled results only
// - settled-only ignored multichannel or fast-settling sinc5
// - settled-only ready pulses once per settling time
// - sinc3 step needs three outputs to settle
// - enhanced filters postfilter the sinc5 words, not the sinc1 averages
// - enhanced 27.27 SPS settles in 36.67 ms
// - enhanced 25 SPS settles in 40 ms
// - enhanced 20 SPS settles in 50 ms
// - enhanced 16.667 SPS settles in 60 ms
// - filter and rate come from channel's setup
// - external clock enters on clock io pin
// - rates assume 2 MHz master, scale proportionally
// - clock source field selects, internal after reset

module sdf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic wr;
  logic rd;

  assign in_ready = cnt != (AW+1)'(DEPTH);
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (wr) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (wr) begin
        wp <= wp + 1'b1;
      end
      if (rd) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule : sdf_fifo

module sdf_decim_filter (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] clock_source_select,
  input wire logic int_osc_tick,
  input wire logic xtal_tick,
  input wire logic clock_io_pin,
  output logic clock_io_out,
  output logic clock_io_oe,
  output logic mod_clk_en,
  input wire logic mod_bit,
  input wire sdf_pkg::sdf_filter_config_t [sdf_pkg::NUM_SETUPS-1:0] filter_config,
  input wire logic [sdf_pkg::SETUP_W-1:0] setup_sel,
  input wire logic conv_start,
  input wire logic multi_chan,
  input wire logic settled_only_select,
  output logic conv_ready,
  output logic overrun,
  output logic out_valid,
  input wire logic out_ready,
  output sdf_pkg::sdf_result_t out_result
);
  // averaging count of sinc1, also the sinc3 rate multiple
  function automatic logic [14:0] odr_factor(input logic [4:0] idx);
    case (idx)
      5'h00: odr_factor = 15'h0001;
      5'h01: odr_factor = 15'h0002;
      5'h02: odr_factor = 15'h0004;
      5'h03: odr_factor = 15'h0006;
      5'h04: odr_factor = 15'h000c;
      5'h05: odr_factor = 15'h0019;
      5'h06: odr_factor = 15'h0032;
      5'h07: odr_factor = 15'h007d;
      5'h08: odr_factor = 15'h00fa;
      5'h09: odr_factor = 15'h0271;
      5'h0a: odr_factor = 15'h04e2;
      5'h0b: odr_factor = 15'h0c35;
      default: odr_factor = 15'h61a8;
    endcase
  endfunction : odr_factor

  function automatic logic [sdf_pkg::ENH_W-1:0] enh_period(input logic [1:0] idx);
    case (idx)
      2'h0: enh_period = sdf_pkg::ENH27_TICKS;
      2'h1: enh_period = sdf_pkg::ENH25_TICKS;
      2'h2: enh_period = sdf_pkg::ENH20_TICKS;
      default: enh_period = sdf_pkg::ENH16_TICKS;
    endcase
  endfunction : enh_period

  sdf_pkg::sdf_clksrc_t clk_sel;
  logic pin_q;
  logic osc_lvl;
  logic master_tick;
  logic mod_phase;
  logic mt;

  always_ff @(posedge clock) begin
    if (rst) begin
      clk_sel <= sdf_pkg::CLKSEL_RESET;
    end else begin
      clk_sel <= sdf_pkg::sdf_clksrc_t'(clock_source_select);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_q <= 1'b0;
      osc_lvl <= 1'b0;
      mod_phase <= 1'b0;
    end else begin
      pin_q <= clock_io_pin;
      osc_lvl <= osc_lvl ^ int_osc_tick;
      mod_phase <= mod_phase ^ master_tick;
    end
  end

  always_comb begin
    case (clk_sel)
      sdf_pkg::SDF_CK_EXT: master_tick = clock_io_pin && !pin_q;
      sdf_pkg::SDF_CK_XTAL: master_tick = xtal_tick;
      default: master_tick = int_osc_tick;
    endcase
  end

  // modulator runs at half the master clock, so all rates scale with it
  assign mt = master_tick && mod_phase;
  assign mod_clk_en = mt;
  assign clock_io_out = osc_lvl;
  assign clock_io_oe = clk_sel == sdf_pkg::SDF_CK_INT_OUT;

  sdf_pkg::sdf_filter_config_t cfg;
  logic [sdf_pkg::SETUP_W-1:0] cur_setup;

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg <= '0;
      cur_setup <= '0;
    end else if (conv_start) begin
      cfg <= filter_config[setup_sel];
      cur_setup <= setup_sel;
    end
  end

  sdf_pkg::sdf_ftype_t ftype;
  logic [14:0] nfac;
  logic [14:0] r3;
  logic [sdf_pkg::D3_W-1:0] d3;
  logic is_s5;
  logic single_s5;
  logic so_eff;
  logic [2:0] settle_n;

  always_comb begin
    if (cfg.decimation_map_select) begin
      ftype = sdf_pkg::SDF_FT_SINC3;
      r3 = cfg.field;
    end else begin
      ftype = sdf_pkg::sdf_ftype_t'(cfg.field[sdf_pkg::TYPE_LSB +: 2]);
      r3 = odr_factor(cfg.field[sdf_pkg::RATE_W-1:0]);
    end
  end

  assign nfac = odr_factor(cfg.field[sdf_pkg::RATE_W-1:0]);
  // a zero decimation value would stall sinc3, so it acts as one
  assign d3 = {(r3 == '0) ? 15'h0001 : r3, 5'h00};
  assign is_s5 = ftype == sdf_pkg::SDF_FT_SINC5 || ftype == sdf_pkg::SDF_FT_RSVD;
  assign single_s5 = is_s5 && nfac >= 15'(sdf_pkg::SINGLE_CYC_MIN_AVG);
  assign so_eff = settled_only_select && !multi_chan && !single_s5;

  always_comb begin
    if (ftype == sdf_pkg::SDF_FT_SINC3) begin
      settle_n = 3'(sdf_pkg::SINC3_SETTLE);
    end else if (ftype == sdf_pkg::SDF_FT_ENH || single_s5) begin
      settle_n = 3'h1;
    end else begin
      settle_n = 3'h1 + 3'((nfac + 15'(sdf_pkg::SINC5_PRIME) - 15'h1) / nfac);
    end
  end

  // sinc5 cic, restarted by every conversion start
  logic [sdf_pkg::S5_W-1:0] i5 [sdf_pkg::SINC5_ORDER];
  logic [sdf_pkg::S5_W-1:0] dly5 [sdf_pkg::SINC5_ORDER];
  logic [sdf_pkg::S5_W-1:0] c5 [sdf_pkg::SINC5_ORDER+1];
  logic [sdf_pkg::S5_W-1:0] n5 [sdf_pkg::SINC5_ORDER];
  logic [4:0] cnt5;
  logic s5_stb;
  logic s5_v;
  logic [sdf_pkg::S5_W-1:0] s5_data;
  logic [2:0] p5;
  logic s5_use;

  assign s5_stb = mt && cnt5 == 5'(sdf_pkg::SINC5_DECIM - 1);

  // integrators chain within one tick: a pipelined chain shifts the
  // window by a tick and leaves the first settled word one count short
  always_comb begin
    n5[0] = i5[0] + sdf_pkg::S5_W'(mod_bit);
    for (int k = 1; k < sdf_pkg::SINC5_ORDER; k++) begin
      n5[k] = i5[k] + n5[k-1];
    end
    c5[0] = i5[sdf_pkg::SINC5_ORDER-1];
    for (int k = 0; k < sdf_pkg::SINC5_ORDER; k++) begin
      c5[k+1] = c5[k] - dly5[k];
    end
  end

  always_ff @(posedge clock) begin
    if (rst || conv_start) begin
      cnt5 <= '0;
      s5_v <= 1'b0;
      s5_data <= '0;
      for (int k = 0; k < sdf_pkg::SINC5_ORDER; k++) begin
        i5[k] <= '0;
        dly5[k] <= '0;
      end
    end else begin
      s5_v <= s5_stb;
      if (mt) begin
        cnt5 <= cnt5 + 5'h1;
        for (int k = 0; k < sdf_pkg::SINC5_ORDER; k++) begin
          i5[k] <= n5[k];
        end
      end
      if (s5_stb) begin
        s5_data <= c5[sdf_pkg::SINC5_ORDER];
        for (int k = 0; k < sdf_pkg::SINC5_ORDER; k++) begin
          dly5[k] <= c5[k];
        end
      end
    end
  end

  // on the slow sinc5+sinc1 rates the partial sinc5 samples are dropped,
  // so the first averaged word is already settled
  always_ff @(posedge clock) begin
    if (rst || conv_start) begin
      p5 <= '0;
    end else if (s5_v && p5 != 3'(sdf_pkg::SINC5_PRIME)) begin
      p5 <= p5 + 3'h1;
    end
  end

  assign s5_use = s5_v && (!single_s5 || p5 == 3'(sdf_pkg::SINC5_PRIME));

  // sinc1 averaging and enhanced postfilter both feed on sinc5 words
  logic [sdf_pkg::DATA_W-1:0] acc1;
  logic [14:0] n1;
  logic raw5_stb;
  logic [sdf_pkg::DATA_W-1:0] acce;
  logic [sdf_pkg::ENH_W-1:0] te;
  logic rawe_stb;

  assign raw5_stb = is_s5 && s5_use && n1 == nfac - 15'h1;
  assign rawe_stb = ftype == sdf_pkg::SDF_FT_ENH && mt
    && te == enh_period(cfg.field[1:0]) - 1'b1;

  always_ff @(posedge clock) begin
    if (rst || conv_start || raw5_stb) begin
      acc1 <= '0;
      n1 <= '0;
    end else if (s5_use) begin
      acc1 <= acc1 + sdf_pkg::DATA_W'(s5_data);
      n1 <= n1 + 15'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || conv_start) begin
      acce <= '0;
      te <= '0;
    end else begin
      if (rawe_stb) begin
        acce <= '0;
        te <= '0;
      end else begin
        if (mt) begin
          te <= te + 1'b1;
        end
        if (s5_use) begin
          acce <= acce + sdf_pkg::DATA_W'(s5_data);
        end
      end
    end
  end

  // sinc3 cic with a programmable decimation of 32 times the rate value
  logic [sdf_pkg::S3_W-1:0] i3 [sdf_pkg::SINC3_ORDER];
  logic [sdf_pkg::S3_W-1:0] dly3 [sdf_pkg::SINC3_ORDER];
  logic [sdf_pkg::S3_W-1:0] c3 [sdf_pkg::SINC3_ORDER+1];
  logic [sdf_pkg::S3_W-1:0] n3 [sdf_pkg::SINC3_ORDER];
  logic [sdf_pkg::D3_W-1:0] cnt3;
  logic s3_stb;

  assign s3_stb = ftype == sdf_pkg::SDF_FT_SINC3 && mt && cnt3 == d3 - 1'b1;

  always_comb begin
    n3[0] = i3[0] + sdf_pkg::S3_W'(mod_bit);
    for (int k = 1; k < sdf_pkg::SINC3_ORDER; k++) begin
      n3[k] = i3[k] + n3[k-1];
    end
    c3[0] = i3[sdf_pkg::SINC3_ORDER-1];
    for (int k = 0; k < sdf_pkg::SINC3_ORDER; k++) begin
      c3[k+1] = c3[k] - dly3[k];
    end
  end

  always_ff @(posedge clock) begin
    if (rst || conv_start) begin
      cnt3 <= '0;
      for (int k = 0; k < sdf_pkg::SINC3_ORDER; k++) begin
        i3[k] <= '0;
        dly3[k] <= '0;
      end
    end else if (mt) begin
      cnt3 <= s3_stb ? '0 : cnt3 + 1'b1;
      for (int k = 0; k < sdf_pkg::SINC3_ORDER; k++) begin
        i3[k] <= n3[k];
      end
      if (s3_stb) begin
        for (int k = 0; k < sdf_pkg::SINC3_ORDER; k++) begin
          dly3[k] <= c3[k];
        end
      end
    end
  end

  // output selection, settling bookkeeping and settled-only throttling
  logic raw_stb;
  logic [sdf_pkg::DATA_W-1:0] raw_data;
  logic [2:0] seen;
  logic [2:0] ocnt;
  logic emit_stb;
  logic emit_settled;
  logic pend_v;
  sdf_pkg::sdf_result_t pend;
  logic fifo_in_ready;

  always_comb begin
    case (ftype)
      sdf_pkg::SDF_FT_SINC3: begin
        raw_stb = s3_stb;
        raw_data = sdf_pkg::DATA_W'(c3[sdf_pkg::SINC3_ORDER]);
      end
      sdf_pkg::SDF_FT_ENH: begin
        raw_stb = rawe_stb;
        raw_data = acce;
      end
      default: begin
        raw_stb = raw5_stb;
        raw_data = acc1 + sdf_pkg::DATA_W'(s5_data);
      end
    endcase
  end

  assign emit_settled = seen >= settle_n - 3'h1;
  assign emit_stb = raw_stb && (!so_eff || ocnt == settle_n - 3'h1);

  always_ff @(posedge clock) begin
    if (rst || conv_start) begin
      seen <= '0;
      ocnt <= '0;
    end else if (raw_stb) begin
      seen <= (seen == 3'h7) ? seen : seen + 3'h1;
      ocnt <= (ocnt >= settle_n - 3'h1) ? '0 : ocnt + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      conv_ready <= 1'b0;
      pend_v <= 1'b0;
      pend <= '0;
      overrun <= 1'b0;
    end else begin
      conv_ready <= emit_stb;
      if (emit_stb) begin
        pend_v <= 1'b1;
        pend <= '{data: raw_data, setup: cur_setup, settled: emit_settled};
      end else if (fifo_in_ready) begin
        pend_v <= 1'b0;
      end
      // a new result wins over the clear at conversion start
      if (emit_stb && pend_v && !fifo_in_ready) begin
        overrun <= 1'b1;
      end else if (conv_start) begin
        overrun <= 1'b0;
      end
    end
  end

  sdf_fifo #(
    .WIDTH($bits(sdf_pkg::sdf_result_t)),
    .DEPTH(sdf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(pend_v),
    .in_ready(fifo_in_ready),
    .in_data(pend),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_result)
  );

  // checking helpers: modulator ticks since the previous output
  logic [5:0] g5;
  logic [sdf_pkg::D3_W-1:0] g3;

  always_ff @(posedge clock) begin
    if (rst || conv_start) begin
      g5 <= '0;
      g3 <= '0;
    end else begin
      if (s5_stb) begin
        g5 <= '0;
      end else if (mt) begin
        g5 <= g5 + 6'h1;
      end
      if (s3_stb) begin
        g3 <= '0;
      end else if (mt) begin
        g3 <= g3 + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || conv_start);

  property p_sinc5_rate;
    s5_stb |-> g5 == 6'd31 ##1 s5_v;
  endproperty
  a_sinc5_rate: assert property (p_sinc5_rate) else $error("sinc5 rate wrong");

  property p_direct_decim;
    s3_stb && cfg.decimation_map_select |-> g3 == {cfg.field, 5'h00} - 1'b1;
  endproperty
  a_direct_decim: assert property (p_direct_decim) else $error("direct rate wrong");

  property p_single_cycle;
    raw5_stb && single_s5 |-> emit_settled && emit_stb;
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("sinc5 not settled");

  property p_sinc3_settle;
    raw_stb && ftype == sdf_pkg::SDF_FT_SINC3 |-> emit_settled == (seen >= 3'h2);
  endproperty
  a_sinc3_settle: assert property (p_sinc3_settle) else $error("sinc3 settle wrong");

  property p_settled_only;
    emit_stb && so_eff |-> emit_settled ##1 conv_ready;
  endproperty
  a_settled_only: assert property (p_settled_only) else $error("unsettled emit");

  property p_multi;
    raw_stb && multi_chan |-> emit_stb ##1 conv_ready;
  endproperty
  a_multi: assert property (p_multi) else $error("output suppressed");

  property p_enh_period;
    rawe_stb |=> te == '0 && acce == '0;
  endproperty
  a_enh_period: assert property (p_enh_period) else $error("enhanced restart");

  property p_clk_reset;
    @(posedge clock) disable iff (1'b0) rst |=> clk_sel == sdf_pkg::SDF_CK_INT;
  endproperty
  a_clk_reset: assert property (p_clk_reset) else $error("clock source reset");

  property p_ext_clk;
    clk_sel == sdf_pkg::SDF_CK_EXT && clock_io_pin && !pin_q |-> master_tick;
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("external edge lost");

  c_sinc3: cover property (s3_stb && cfg.decimation_map_select);
  c_enh: cover property (rawe_stb);
  c_so: cover property (emit_stb && so_eff);
  c_ovr: cover property (emit_stb && pend_v && !fifo_in_ready);
endmodule : sdf_decim_filter

// [sdf_pkg.sv]
package sdf_pkg;
  localparam int DATA_W = 64;
  localparam int NUM_SETUPS = 8;
  localparam int SETUP_W = 3;
  localparam int MCLK_HZ = 2000000;
  localparam int MOD_DIV = 2;
  localparam int MOD_HZ = MCLK_HZ / MOD_DIV;
  localparam int SINC5_DECIM = 32;
  localparam int SINC5_HZ = MOD_HZ / SINC5_DECIM;
  localparam int SINGLE_CYC_ODR_HZ = 2600;
  // 31250/2600 floors to 12, whose rate of 2604 SPS counts as 2.6k
  localparam int SINGLE_CYC_MIN_AVG = SINC5_HZ / SINGLE_CYC_ODR_HZ;
  localparam int SINC5_ORDER = 5;
  localparam int SINC5_PRIME = SINC5_ORDER - 1;
  localparam int SINC3_ORDER = 3;
  localparam int SINC3_SETTLE = 3;
  localparam int SINC3_UNIT = 32;
  localparam int S5_W = 26;
  localparam int S3_W = 61;
  localparam int D3_W = 20;
  localparam int MAP_BIT = 15;
  localparam int DEC_W = 15;
  localparam int TYPE_LSB = 5;
  localparam int RATE_W = 5;
  localparam int US_PER_S = 1000000;
  localparam int ENH27_SETTLE_US = 36670;
  localparam int ENH25_SETTLE_US = 40000;
  localparam int ENH20_SETTLE_US = 50000;
  localparam int ENH16_SETTLE_US = 60000;
  localparam int ENH_W = 17;
  localparam logic [ENH_W-1:0] ENH27_TICKS = ENH_W'(longint'(ENH27_SETTLE_US) * MOD_HZ / US_PER_S);
  localparam logic [ENH_W-1:0] ENH25_TICKS = ENH_W'(longint'(ENH25_SETTLE_US) * MOD_HZ / US_PER_S);
  localparam logic [ENH_W-1:0] ENH20_TICKS = ENH_W'(longint'(ENH20_SETTLE_US) * MOD_HZ / US_PER_S);
  localparam logic [ENH_W-1:0] ENH16_TICKS = ENH_W'(longint'(ENH16_SETTLE_US) * MOD_HZ / US_PER_S);
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    SDF_FT_SINC5 = 2'b00,
    SDF_FT_RSVD = 2'b01,
    SDF_FT_ENH = 2'b10,
    SDF_FT_SINC3 = 2'b11
  } sdf_ftype_t;

  typedef enum logic [1:0] {
    SDF_CK_INT = 2'b00,
    SDF_CK_INT_OUT = 2'b01,
    SDF_CK_EXT = 2'b10,
    SDF_CK_XTAL = 2'b11
  } sdf_clksrc_t;

  localparam sdf_clksrc_t CLKSEL_RESET = SDF_CK_INT;

  typedef struct packed {
    logic decimation_map_select;
    logic [DEC_W-1:0] field;
  } sdf_filter_config_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [SETUP_W-1:0] setup;
    logic settled;
  } sdf_result_t;
endpackage : sdf_pkg

// [sdf_mod_model.sv]
module sdf_mod_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic int_en,
  input wire logic ext_en,
  input wire logic bit_level,
  output logic int_osc_tick,
  output logic xtal_tick,
  output logic clock_io_pin,
  output logic mod_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph;
  logic [6:0] warm;

  initial begin
    ph = 1'b0;
    warm = 7'h00;
    int_osc_tick = 1'b0;
    xtal_tick = 1'b0;
    clock_io_pin = 1'b0;
    mod_bit = 1'b0;
  end

  // master ticks two cycles apart, the closest spacing the filter accepts
  always @(negedge clock) begin
    ph <= !ph;
    int_osc_tick <= int_en && ph;
    if (rst) begin
      warm <= 7'h00;
    end else if (!warm[6]) begin
      warm <= warm + 7'h01;
    end
    // no crystal edges until the oscillator has built up
    xtal_tick <= warm[6] && ph;
    // external clock only toggles while ext_en is high, else it stands still
    if (ext_en) begin
      clock_io_pin <= !clock_io_pin;
    end
    mod_bit <= bit_level;
  end
endmodule : sdf_mod_model

// [tb_sdf_decim_filter.sv]
module tb_sdf_decim_filter;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, int_tk, xtal_tk, pin, io_out, io_oe, mod_en, mbit;
  logic [1:0] cs;
  sdf_pkg::sdf_filter_config_t [sdf_pkg::NUM_SETUPS-1:0] fc;
  logic [2:0] setup_sel, cur_s;
  logic conv_start, multi_chan, sel_only, conv_ready, overrun, out_valid, out_ready;
  logic int_en, ext_en, bit_level;
  sdf_pkg::sdf_result_t out_result;
  sdf_pkg::sdf_result_t rq[$];
  int gq[$];
  int tcnt, n_fail, num_checks, c;
  logic a;

  sdf_decim_filter sdf_decim_filter_inst (.clock(clock), .rst(rst),
    .clock_source_select(cs), .int_osc_tick(int_tk), .xtal_tick(xtal_tk),
    .clock_io_pin(pin), .clock_io_out(io_out), .clock_io_oe(io_oe),
    .mod_clk_en(mod_en), .mod_bit(mbit), .filter_config(fc), .setup_sel(setup_sel),
    .conv_start(conv_start), .multi_chan(multi_chan), .settled_only_select(sel_only),
    .conv_ready(conv_ready), .overrun(overrun), .out_valid(out_valid),
    .out_ready(out_ready), .out_result(out_result));

  sdf_mod_model sdf_mod_model_inst (.clock(clock), .rst(rst), .int_en(int_en),
    .ext_en(ext_en), .bit_level(bit_level), .int_osc_tick(int_tk),
    .xtal_tick(xtal_tk), .clock_io_pin(pin), .mod_bit(mbit));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // each modulator tick lands in exactly one gap, so gaps add up
  always @(posedge clock) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) rq.push_back(out_result);
    if (conv_ready === 1'b1) begin
      gq.push_back(tcnt);
      tcnt = 0;
    end
    if (mod_en === 1'b1) tcnt++;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic cnt(output int n);
    n = 0;
    repeat (4) @(posedge clock);
    repeat (40) begin
      @(posedge clock);
      if (mod_en === 1'b1) n++;
    end
    @(negedge clock);
  endtask : cnt

  task automatic start(input logic [2:0] s, input logic [15:0] cfg);
    @(negedge clock);
    fc[s] = sdf_pkg::sdf_filter_config_t'(cfg);
    setup_sel = s;
    cur_s = s;
    conv_start = 1'b1;
    @(negedge clock);
    conv_start = 1'b0;
    repeat (3) @(negedge clock);
    rq.delete();
    gq.delete();
  endtask : start

  // waits for n popped results or n ready pulses, whichever comes first
  task automatic wait_n(input int n);
    int k;
    for (k = 0; k < 30000 && rq.size() < n && gq.size() < n; k++) @(posedge clock);
    if (k == 30000) chk(64'h0, 64'h1);
    // ready pulse leads the pop by a cycle, let the last word land
    repeat (3) @(negedge clock);
  endtask : wait_n

  task automatic run(input logic [2:0] s, input logic [15:0] cfg, input int n, input int gap);
    int i;
    start(s, cfg);
    wait_n(n);
    for (i = 1; i < n; i++) chk(64'(gq[i]), 64'(gap));
    chk(64'(rq[0].setup), 64'(s));
  endtask : run

  initial begin
    n_fail = 0;
    num_checks = 0;
    tcnt = 0;
    rst = 1'b1;
    cs = 2'b00;
    fc = '0;
    setup_sel = 3'h0;
    cur_s = 3'h0;
    conv_start = 1'b0;
    multi_chan = 1'b0;
    sel_only = 1'b0;
    out_ready = 1'b1;
    int_en = 1'b1;
    ext_en = 1'b0;
    bit_level = 1'b1;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    chk(64'({conv_ready, overrun, out_valid, io_oe, io_out}), 64'h0);
    cnt(c);
    chk(64'(c >= 9 && c <= 11), 64'h1);
    cs = 2'b01;
    repeat (4) @(negedge clock);
    chk(64'(io_oe), 64'h1);
    a = io_out;
    repeat (2) @(negedge clock);
    chk(64'(io_out), 64'(!a));
    cs = 2'b10;
    cnt(c);
    chk(64'(c), 64'h0);
    @(negedge clock);
    ext_en = 1'b1;
    cnt(c);
    chk(64'(c >= 9 && c <= 11), 64'h1);
    @(negedge clock);
    cs = 2'b00;
    int_en = 1'b0;
    cnt(c);
    chk(64'(c), 64'h0);
    @(negedge clock);
    cs = 2'b11;
    ext_en = 1'b0;
    cnt(c);
    chk(64'(c >= 9 && c <= 11), 64'h1);
    @(negedge clock);
    cs = 2'b00;
    int_en = 1'b1;
    run(3'h0, 16'h0000, 6, 32);
    chk(64'(rq[3].settled), 64'h0);
    chk({rq[4].data[63:1], rq[4].settled}, 64'h200_0001);
    run(3'h3, 16'h0004, 3, 384);
    chk(rq[0].data, 64'h1800_0000);
    chk(64'(rq[0].settled), 64'h1);
    sel_only = 1'b1;
    run(3'h3, 16'h0004, 3, 384);
    sel_only = 1'b0;
    run(3'h5, 16'h8002, 4, 64);
    chk(64'(rq[1].settled), 64'h0);
    chk(64'(rq[2].settled), 64'h1);
    chk(rq[2].data, 64'h4_0000);
    run(3'h6, 16'h0060, 3, 32);
    chk(rq[2].data, 64'h8000);
    sel_only = 1'b1;
    run(3'h5, 16'h8002, 3, 192);
    chk(64'({rq[0].settled, rq[1].settled, rq[2].settled}), 64'h7);
    chk(rq[0].data, 64'h4_0000);
    multi_chan = 1'b1;
    run(3'h5, 16'h8002, 3, 64);
    chk(64'(rq[0].settled), 64'h0);
    multi_chan = 1'b0;
    sel_only = 1'b0;
    // stalled consumer: 16 stored, one pending, the 18th overwrites it
    out_ready = 1'b0;
    start(3'h1, 16'h0000);
    wait_n(17);
    chk(64'({overrun, out_valid}), 64'h1);
    wait_n(18);
    repeat (2) @(negedge clock);
    chk(64'({overrun, out_valid}), 64'h3);
    int_en = 1'b0;
    repeat (10) @(negedge clock);
    out_ready = 1'b1;
    repeat (60) @(negedge clock);
    chk(64'(rq.size()), 64'd17);
    chk(64'({overrun, out_valid}), 64'h2);
    chk(64'(rq[16].settled), 64'h1);
    start(3'h1, 16'h0000);
    chk(64'(overrun), 64'h0);
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    report_and_stop();
  end
endmodule : tb_sdf_decim_filter
